/* common/isrp_defs.vh */
/*
  constants for the serial secondary register port: pointer values,
  reset values, address pattern, timing counts.
  assumes a 250 MHz system clock; included by bare name.
*/
// Overview of operation
// - port is target only; never drives clock, never starts transfers.
// - runs up to 400 kHz fast mode and 2.94 MHz after high-speed entry.
// - register words cross the link upper byte first, both directions.
// - address is 100 then high-select code then low-select code.
// - both select pins re-sampled at every transaction start.
// - first write byte after address loads the register pointer.
// - matching address, pointer byte and write data bytes are acknowledged.
// - two bytes after pointer stored to pointed register, upper first.
// - pointer-only write accepted, updates only the pointer.
// - read returns upper byte, then lower after controller acknowledge.
// - not-acknowledge, start or stop ends read data drive.
// - pointer persists across transfers until a new pointer write.
// - no clock stretching, no packet error code handling.
// - master code 00001XXX not acknowledged, switches to high-speed filter.
// - repeated starts keep high-speed mode; stop returns to fast filter.
// - with alert active, acknowledge alert-response read, send own address.
// - alert response uses arbitration; loser stops, keeps alert asserted.
`ifndef ISRP_DEFS_VH
`define ISRP_DEFS_VH

// ----------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------
`define ISRP_PTR_GEN_CFG 8'h00
`define ISRP_PTR_CONV_SETUP 8'h01
`define ISRP_PTR_SENSE_SCALE 8'h02
`define ISRP_PTR_SENSE_V 8'h04
`define ISRP_PTR_RAIL_V 8'h05
`define ISRP_PTR_DIE_HEAT 8'h06
`define ISRP_PTR_CURRENT 8'h07
`define ISRP_PTR_POWER 8'h08
`define ISRP_PTR_FAULT 8'h0B
`define ISRP_PTR_SENSE_UL 8'h0C
`define ISRP_PTR_SENSE_LL 8'h0D
`define ISRP_PTR_RAIL_UL 8'h0E
`define ISRP_PTR_RAIL_LL 8'h0F
`define ISRP_PTR_HEAT_UL 8'h10
`define ISRP_PTR_POWER_UL 8'h11
`define ISRP_PTR_MAKER 8'h3E

// ----------------------------------------------------------------
// reset values of writable registers
// ----------------------------------------------------------------
`define ISRP_RST_GEN_CFG 16'h0000
`define ISRP_RST_CONV_SETUP 16'hFB68
`define ISRP_RST_SENSE_SCALE 16'h1000
`define ISRP_RST_SENSE_UL 16'h7FFF
`define ISRP_RST_SENSE_LL 16'h8000
`define ISRP_RST_RAIL_UL 16'h7FFF
`define ISRP_RST_RAIL_LL 16'h0000
`define ISRP_RST_HEAT_UL 16'hFFFF
`define ISRP_RST_POWER_UL 16'h7FFF
// arbitrary maker code value
`define ISRP_MAKER_CODE 16'h5A5A

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define ISRP_CFG_SWRST_BIT 15
`define ISRP_CFG_WMASK 16'h3FF0
`define ISRP_SCALE_WMASK 16'h7FFF
`define ISRP_FAULT_WMASK 16'hF000
`define ISRP_ADDR_PREFIX 3'b100
`define ISRP_ALERT_RESP_ADDR 7'h0C
`define ISRP_HS_CODE_TOP 5'b00001

// ----------------------------------------------------------------
// timing: glitch filter lengths in system cycles
// ----------------------------------------------------------------
`define ISRP_CLK_MHZ 250
`define ISRP_FS_SPIKE_NS 50
`define ISRP_HS_SPIKE_NS 10
`define ISRP_FS_FILT ((`ISRP_FS_SPIKE_NS * `ISRP_CLK_MHZ) / 1000)
`define ISRP_HS_FILT ((`ISRP_HS_SPIKE_NS * `ISRP_CLK_MHZ) / 1000)

`endif

/* src/isrp_filter.v */
/*
  glitch filter for one bus line: synchronises the pin and passes a
  new level only after it has held for the selected number of cycles.
  assumes clk_sys well above the bus rate.
*/
`timescale 1ns/1ps
module isrp_filter (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire pin_in,
  input wire [3:0] hold_cnt,
  output reg level_r
);
  reg sync1_r;
  reg sync2_r;
  reg [3:0] cnt_r;

  // ----------------------------------------------------------------
  // two-stage sync then hold counter; idle level of a pulled line is 1
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      cnt_r <= 4'h0;
      level_r <= 1'b1;
    end else if (clk_en) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      if (sync2_r == level_r) begin
        cnt_r <= 4'h0;
      end else if (cnt_r >= hold_cnt) begin
        level_r <= sync2_r;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

/* src/isrp_port.v */
/*
  serial secondary register port: bus target protocol engine, register
  pointer and the writable register file, plus alert-response identity.
  assumes open-drain lines resolved outside; measurement results and
  alert state arrive from core logic on clk_sys.
*/
`timescale 1ns/1ps
`include "isrp_defs.vh"
module isrp_port (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  output wire scl_out,
  output wire scl_oe,
  input wire [1:0] addr_select_low_pin,
  input wire [1:0] addr_select_high_pin,
  input wire alert_active,
  output reg alert_won_r,
  output reg hs_mode_r,
  output reg fault_read_r,
  input wire [15:0] sense_voltage_result,
  input wire [15:0] supply_rail_result,
  input wire [15:0] die_heat_result,
  input wire [15:0] current_result,
  input wire [23:0] power_result,
  input wire [15:0] fault_status,
  output reg [15:0] general_config_r,
  output reg [15:0] conversion_setup_r,
  output reg [15:0] sense_resistor_scale_r,
  output reg [15:0] fault_ctrl_r,
  output reg [15:0] sense_upper_limit_r,
  output reg [15:0] sense_lower_limit_r,
  output reg [15:0] rail_upper_limit_r,
  output reg [15:0] rail_lower_limit_r,
  output reg [15:0] heat_upper_limit_r,
  output reg [15:0] power_upper_limit_r,
  output reg soft_reset_r,
  output reg [7:0] reg_ptr_r
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 7'b0000001;
  localparam ST_ADDR = 7'b0000010;
  localparam ST_AACK = 7'b0000100;
  localparam ST_WBYTE = 7'b0001000;
  localparam ST_WACK = 7'b0010000;
  localparam ST_RBYTE = 7'b0100000;
  localparam ST_RACK = 7'b1000000;
  // filter lengths are cut to the hold counter width on purpose
  localparam [31:0] FS_FILT_W = `ISRP_FS_FILT;
  localparam [31:0] HS_FILT_W = `ISRP_HS_FILT;

  wire scl_f;
  wire sda_f;
  wire [3:0] filt_len;
  reg scl_d_r;
  reg sda_d_r;
  reg [6:0] st_r;
  reg [7:0] shift_r;
  reg [3:0] bit_r;
  reg [1:0] wcnt_r;
  reg [7:0] hi_byte_r;
  reg rd_hi_r;
  reg ara_r;
  reg [23:0] rdata_r;
  reg sda_drv_r;
  reg [6:0] own_addr_r;
  reg [1:0] sel_lo_s1_r;
  reg [1:0] sel_lo_s2_r;
  reg [1:0] sel_hi_s1_r;
  reg [1:0] sel_hi_s2_r;
  reg [23:0] rd_mux;

  // filter length follows the speed mode
  assign filt_len = hs_mode_r ? HS_FILT_W[3:0] :
    FS_FILT_W[3:0];

  isrp_filter u_scl_filt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(scl_in),
    .hold_cnt(filt_len),
    .level_r(scl_f)
  );

  isrp_filter u_sda_filt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(sda_in),
    .hold_cnt(filt_len),
    .level_r(sda_f)
  );

  // ----------------------------------------------------------------
  // bus edges and conditions
  // ----------------------------------------------------------------
  wire scl_rise = scl_f & ~scl_d_r;
  wire scl_fall = ~scl_f & scl_d_r;
  wire start_c = scl_f & scl_d_r & sda_d_r & ~sda_f;
  wire stop_c = scl_f & scl_d_r & ~sda_d_r & sda_f;
  wire [7:0] byte_in = {shift_r[6:0], sda_f};

  // target only: the clock line is never driven, so no stretching
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  // open drain: drive means pull low
  assign sda_out = 1'b0;
  assign sda_oe = sda_drv_r;

  // ----------------------------------------------------------------
  // read data selection by pointer
  // ----------------------------------------------------------------
  always @* begin
    case (reg_ptr_r)
      `ISRP_PTR_GEN_CFG: rd_mux = {8'h00, general_config_r};
      `ISRP_PTR_CONV_SETUP: rd_mux = {8'h00, conversion_setup_r};
      `ISRP_PTR_SENSE_SCALE: rd_mux = {8'h00, sense_resistor_scale_r};
      `ISRP_PTR_SENSE_V: rd_mux = {8'h00, sense_voltage_result};
      `ISRP_PTR_RAIL_V: rd_mux = {8'h00, supply_rail_result};
      `ISRP_PTR_DIE_HEAT: rd_mux = {8'h00, die_heat_result};
      `ISRP_PTR_CURRENT: rd_mux = {8'h00, current_result};
      `ISRP_PTR_POWER: rd_mux = power_result;
      `ISRP_PTR_FAULT:
        rd_mux = {8'h00, fault_ctrl_r | (fault_status & 16'h0FFF)};
      `ISRP_PTR_SENSE_UL: rd_mux = {8'h00, sense_upper_limit_r};
      `ISRP_PTR_SENSE_LL: rd_mux = {8'h00, sense_lower_limit_r};
      `ISRP_PTR_RAIL_UL: rd_mux = {8'h00, rail_upper_limit_r};
      `ISRP_PTR_RAIL_LL: rd_mux = {8'h00, rail_lower_limit_r};
      `ISRP_PTR_HEAT_UL: rd_mux = {8'h00, heat_upper_limit_r};
      `ISRP_PTR_POWER_UL: rd_mux = {8'h00, power_upper_limit_r};
      `ISRP_PTR_MAKER: rd_mux = {8'h00, `ISRP_MAKER_CODE};
      default: rd_mux = 24'h000000;
    endcase
  end

  // ----------------------------------------------------------------
  // select pin sync; strap codes are pin level pairs from the pad
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_lo_s1_r <= 2'h0;
      sel_lo_s2_r <= 2'h0;
      sel_hi_s1_r <= 2'h0;
      sel_hi_s2_r <= 2'h0;
    end else if (clk_en) begin
      sel_lo_s1_r <= addr_select_low_pin;
      sel_lo_s2_r <= sel_lo_s1_r;
      sel_hi_s1_r <= addr_select_high_pin;
      sel_hi_s2_r <= sel_hi_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // protocol engine; data on sda changes only while scl is low
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n || soft_reset_r) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      st_r <= ST_IDLE;
      shift_r <= 8'h00;
      bit_r <= 4'h0;
      wcnt_r <= 2'h0;
      hi_byte_r <= 8'h00;
      rd_hi_r <= 1'b0;
      ara_r <= 1'b0;
      rdata_r <= 24'h000000;
      sda_drv_r <= 1'b0;
      own_addr_r <= 7'h40;
      hs_mode_r <= 1'b0;
      alert_won_r <= 1'b0;
      fault_read_r <= 1'b0;
      reg_ptr_r <= 8'h00;
      soft_reset_r <= 1'b0;
      general_config_r <= `ISRP_RST_GEN_CFG;
      conversion_setup_r <= `ISRP_RST_CONV_SETUP;
      sense_resistor_scale_r <= `ISRP_RST_SENSE_SCALE;
      fault_ctrl_r <= 16'h0000;
      sense_upper_limit_r <= `ISRP_RST_SENSE_UL;
      sense_lower_limit_r <= `ISRP_RST_SENSE_LL;
      rail_upper_limit_r <= `ISRP_RST_RAIL_UL;
      rail_lower_limit_r <= `ISRP_RST_RAIL_LL;
      heat_upper_limit_r <= `ISRP_RST_HEAT_UL;
      power_upper_limit_r <= `ISRP_RST_POWER_UL;
    end else if (clk_en) begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
      alert_won_r <= 1'b0;
      fault_read_r <= 1'b0;
      if (start_c) begin
        // any start drops the transfer; repeated start keeps hs mode
        st_r <= ST_ADDR;
        bit_r <= 4'h0;
        sda_drv_r <= 1'b0;
        // fresh strap sample at each transaction
        own_addr_r <= {`ISRP_ADDR_PREFIX, sel_hi_s2_r, sel_lo_s2_r};
      end else if (stop_c) begin
        st_r <= ST_IDLE;
        sda_drv_r <= 1'b0;
        hs_mode_r <= 1'b0;
      end else begin
        case (st_r)
          ST_IDLE: begin
            sda_drv_r <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_r <= byte_in;
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              wcnt_r <= 2'h0;
              if (shift_r[7:3] == `ISRP_HS_CODE_TOP) begin
                // master code: no acknowledge, switch filters
                hs_mode_r <= 1'b1;
                st_r <= ST_IDLE;
              end else if (shift_r[7:1] == own_addr_r) begin
                sda_drv_r <= 1'b1;
                ara_r <= 1'b0;
                rd_hi_r <= 1'b1;
                rdata_r <= rd_mux;
                st_r <= ST_AACK;
              end else if (shift_r[7:1] == `ISRP_ALERT_RESP_ADDR &&
                           shift_r[0] && alert_active) begin
                sda_drv_r <= 1'b1;
                ara_r <= 1'b1;
                rdata_r <= {16'h0000, own_addr_r, 1'b1};
                st_r <= ST_AACK;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fall) begin
              if (shift_r[0] && st_r == ST_AACK) begin
                // upper byte leads; first bit placed now
                sda_drv_r <= ara_r ? ~rdata_r[7] : ~rdata_r[15];
                shift_r <= ara_r ? rdata_r[7:0] : rdata_r[15:8];
                bit_r <= 4'h1;
                st_r <= ST_RBYTE;
              end else begin
                sda_drv_r <= 1'b0;
                st_r <= ST_WBYTE;
              end
            end
          end
          ST_WBYTE: begin
            if (scl_rise) begin
              shift_r <= byte_in;
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              sda_drv_r <= 1'b1;
              st_r <= ST_WACK;
              shift_r[0] <= 1'b0;
              if (wcnt_r == 2'h0) begin
                reg_ptr_r <= shift_r;
                wcnt_r <= 2'h1;
              end else if (wcnt_r == 2'h1) begin
                hi_byte_r <= shift_r;
                wcnt_r <= 2'h2;
              end else if (wcnt_r == 2'h2) begin
                // later bytes are acked but never committed again
                wcnt_r <= 2'h3;
                // commit word; unmapped pointers are simply dropped
                case (reg_ptr_r)
                  `ISRP_PTR_GEN_CFG: begin
                    general_config_r <=
                      {hi_byte_r, shift_r} & `ISRP_CFG_WMASK;
                    soft_reset_r <= hi_byte_r[7];
                  end
                  `ISRP_PTR_CONV_SETUP:
                    conversion_setup_r <= {hi_byte_r, shift_r};
                  `ISRP_PTR_SENSE_SCALE: sense_resistor_scale_r <=
                    {hi_byte_r, shift_r} & `ISRP_SCALE_WMASK;
                  `ISRP_PTR_FAULT:
                    fault_ctrl_r <= {hi_byte_r, shift_r} & `ISRP_FAULT_WMASK;
                  `ISRP_PTR_SENSE_UL:
                    sense_upper_limit_r <= {hi_byte_r, shift_r};
                  `ISRP_PTR_SENSE_LL:
                    sense_lower_limit_r <= {hi_byte_r, shift_r};
                  `ISRP_PTR_RAIL_UL:
                    rail_upper_limit_r <= {hi_byte_r, shift_r};
                  `ISRP_PTR_RAIL_LL:
                    rail_lower_limit_r <= {hi_byte_r, shift_r};
                  `ISRP_PTR_HEAT_UL:
                    heat_upper_limit_r <= {hi_byte_r, shift_r};
                  `ISRP_PTR_POWER_UL:
                    power_upper_limit_r <= {hi_byte_r, shift_r};
                  default: begin
                  end
                endcase
              end
            end
          end
          ST_RBYTE: begin
            if (scl_rise && ara_r && sda_f != shift_r[7]) begin
              // lost arbitration: let go, alert stays with core
              sda_drv_r <= 1'b0;
              st_r <= ST_IDLE;
            end else if (scl_fall) begin
              if (bit_r == 4'h8) begin
                sda_drv_r <= 1'b0;
                bit_r <= 4'h0;
                st_r <= ST_RACK;
                if (ara_r) begin
                  alert_won_r <= 1'b1;
                end
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_drv_r <= ~shift_r[6];
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_f || ara_r || !rd_hi_r) begin
                // nack or word done: stop driving
                st_r <= ST_IDLE;
                if (!ara_r && !rd_hi_r && reg_ptr_r == `ISRP_PTR_FAULT) begin
                  fault_read_r <= 1'b1;
                end
              end else begin
                rd_hi_r <= 1'b0;
                if (reg_ptr_r == `ISRP_PTR_FAULT) begin
                  fault_read_r <= 1'b1;
                end
              end
            end else if (scl_fall && st_r == ST_RACK) begin
              shift_r <= rdata_r[7:0];
              sda_drv_r <= ~rdata_r[7];
              bit_r <= 4'h1;
              st_r <= ST_RBYTE;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

/* dv/isrp_props.sv */
/*
  checker for the register port: clock line never driven, acks only
  while the clock is low, pointer and register updates tied to acks,
  high-speed entry and exit, alert identity.
  assumes the top port module's names; bound below its endmodule.
*/
`timescale 1ns/1ps
module isrp_props (
  input wire clk_sys,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe,
  input wire scl_oe,
  input wire alert_active,
  input wire alert_won_r,
  input wire hs_mode_r,
  input wire [7:0] reg_ptr_r,
  input wire [15:0] general_config_r,
  input wire [15:0] sense_upper_limit_r,
  input wire [15:0] sense_lower_limit_r
);
  // ------------------------------------------------------------
  // bus conditions seen on the raw pins
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // raw pins lead the filtered ones, so responses get a window
  sequence stop_seen;
    scl_in && $rose(sda_in);
  endsequence
  sequence start_seen;
    scl_in && $fell(sda_in);
  endsequence
  scl_idle_a: assert property (!scl_oe)
    else $error("clock line driven by the port");
  oe_on_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled low while clock high");
  ptr_on_ack_a: assert property ($changed(reg_ptr_r) |-> sda_oe)
    else $error("pointer moved outside a pointer ack");
  wr_on_ack_a: assert property (($changed(sense_upper_limit_r) ||
    $changed(sense_lower_limit_r) || $changed(general_config_r)) |-> sda_oe)
    else $error("register written outside a data ack");
  hs_enter_a: assert property ($rose(hs_mode_r) |-> !sda_oe [*8])
    else $error("master code acknowledged");
  hs_exit_a: assert property (stop_seen |-> ##[1:40] !hs_mode_r)
    else $error("high-speed mode kept after stop");
  start_rel_a: assert property (start_seen |-> ##[1:40] !sda_oe)
    else $error("data line held after start");
  alert_won_a: assert property (alert_won_r |-> alert_active)
    else $error("alert identity sent without alert");
endmodule

bind isrp_port isrp_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe), .scl_oe(scl_oe),
  .alert_active(alert_active), .alert_won_r(alert_won_r),
  .hs_mode_r(hs_mode_r), .reg_ptr_r(reg_ptr_r),
  .general_config_r(general_config_r),
  .sense_upper_limit_r(sense_upper_limit_r),
  .sense_lower_limit_r(sense_lower_limit_r));

/* dv/isrp_ctl_model.sv */
/*
  bus controller model: open-drain pull-low drivers for clock and
  data, with start, stop and byte tasks called by the bench.
  assumes pull-ups outside and calls aligned just after a clk edge.
*/
`timescale 1ns/1ps
module isrp_ctl_model (
  input wire sda_line,
  output reg scl_low,
  output reg sda_low
);
  // ------------------------------------------------------------
  // bus phases
  // ------------------------------------------------------------
  // quarter bit in ns; 628 keeps fast mode under 400 kHz
  integer qtr = 628;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // one bit: data moves only while the clock is low
  task slot(input logic b, output logic got);
    begin
      #(qtr) sda_low = ~b;
      #(qtr) scl_low = 1'b0;
      #(qtr) got = sda_line;
      #(qtr) scl_low = 1'b1;
    end
  endtask
  // data released before the clock rises, so this is also a restart
  task start;
    begin
      #(qtr) sda_low = 1'b0;
      #(qtr) scl_low = 1'b0;
      #(qtr) sda_low = 1'b1;
      #(qtr) scl_low = 1'b1;
    end
  endtask
  task stop;
    begin
      #(qtr) sda_low = 1'b1;
      #(qtr) scl_low = 1'b0;
      #(qtr) sda_low = 1'b0;
      #(qtr);
    end
  endtask
  // most significant bit first, then the ack slot
  task send_byte(input logic [7:0] d, output logic ack);
    logic g;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) slot(d[i], g);
      slot(1'b1, g);
      ack = ~g;
    end
  endtask
  task recv_byte(input logic ack, output logic [7:0] d);
    logic g;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        slot(1'b1, g);
        d[i] = g;
      end
      slot(~ack, g);
    end
  endtask
endmodule

/* dv/tb_i2c_secondary_register_port.sv */
/*
  self-checking bench for the register port: pointer write in fast mode, word
  traffic in high-speed mode, address straps, abandoned writes, alert identity.
  assumes the controller model and checker are compiled before it.
*/
`timescale 1ns/1ps
`include "isrp_defs.vh"
module tb_i2c_secondary_register_port;
  reg clk_sys, rst_n, alert_active;
  reg [1:0] sel_lo, sel_hi;
  reg [15:0] sv_in, rail_in, heat_in, cur_in, flt_in;
  reg [23:0] pwr_in;
  wire scl_low, sda_low, sda_oe, scl_oe, hs_mode_r, alert_won_r;
  wire fault_rd;
  wire [15:0] sul_q;
  wire scl_line = ~(scl_low | scl_oe);
  wire sda_line = ~(sda_low | sda_oe);
  integer num_errors = 0, samples_checked = 0, won_cnt = 0, i;
  integer frd_cnt = 0;
  reg ack;
  reg [3:0] acks;
  reg [7:0] b;
  reg [15:0] w;

  isrp_ctl_model ctl (.sda_line(sda_line), .scl_low(scl_low),
    .sda_low(sda_low));
  isrp_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
    .scl_in(scl_line), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .scl_out(), .scl_oe(scl_oe), .addr_select_low_pin(sel_lo),
    .addr_select_high_pin(sel_hi), .alert_active(alert_active),
    .alert_won_r(alert_won_r), .hs_mode_r(hs_mode_r),
    .fault_read_r(fault_rd),
    .sense_voltage_result(sv_in), .supply_rail_result(rail_in),
    .die_heat_result(heat_in), .current_result(cur_in),
    .power_result(pwr_in), .fault_status(flt_in), .general_config_r(),
    .conversion_setup_r(), .sense_resistor_scale_r(), .fault_ctrl_r(),
    .sense_upper_limit_r(sul_q), .sense_lower_limit_r(),
    .rail_upper_limit_r(), .rail_lower_limit_r(), .heat_upper_limit_r(),
    .power_upper_limit_r(), .soft_reset_r(), .reg_ptr_r());

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // pulses are one cycle wide, so these count identity sends and
  // fault register byte reads
  always @(posedge clk_sys) begin
    if (alert_won_r === 1'b1) won_cnt <= won_cnt + 1;
    if (fault_rd === 1'b1) frd_cnt <= frd_cnt + 1;
  end
  task chk(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  function [7:0] dev(input rd);
    dev = {3'b100, sel_hi, sel_lo, rd};
  endfunction
  // address, pointer, then n data bytes upper first; no stop
  task wr(input [7:0] ptr, input integer n, input [15:0] d);
    begin
      ctl.start;
      ctl.send_byte(dev(1'b0), acks[0]);
      ctl.send_byte(ptr, acks[1]);
      acks[3:2] = 2'b11;
      if (n > 0) ctl.send_byte(d[15:8], acks[2]);
      if (n > 1) ctl.send_byte(d[7:0], acks[3]);
      chk("write acks", {12'h000, acks}, 16'h000F);
    end
  endtask
  task rd(input [15:0] exp, input string name);
    begin
      ctl.start;
      ctl.send_byte(dev(1'b1), ack);
      ctl.recv_byte(1'b1, w[15:8]);
      ctl.recv_byte(1'b0, w[7:0]);
      chk("read ack", {15'h0000, ack}, 16'h0001);
      chk(name, w, exp);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // a hung transfer would stall the sequence; the run takes ~300 us
  initial begin
    #400000;
    num_errors = num_errors + 1;
    test_done;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    alert_active = 1'b0;
    sel_lo = 2'b10;
    sel_hi = 2'b01;
    sv_in = 16'h1357;
    rail_in = 16'h2468;
    heat_in = 16'h0FF0;
    cur_in = 16'h8001;
    pwr_in = 24'hA5C3E1;
    flt_in = 16'h0123;
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 wr(`ISRP_PTR_CONV_SETUP, 0, 16'h0000);
    // master code at fast rate, then high-speed on repeated starts
    ctl.start;
    ctl.send_byte(8'h0D, ack);
    chk("code ack", {15'h0000, ack}, 16'h0000);
    chk("hs entered", {15'h0000, hs_mode_r}, 16'h0001);
    ctl.qtr = 88;
    rd(`ISRP_RST_CONV_SETUP, "pointer only");
    wr(`ISRP_PTR_SENSE_UL, 2, 16'h1234);
    chk("upper limit", sul_q, 16'h1234);
    rd(16'h1234, "limit readback");
    wr(`ISRP_PTR_SENSE_LL, 1, 16'hAB00);
    rd(`ISRP_RST_SENSE_LL, "abandoned write");
    wr(`ISRP_PTR_RAIL_V, 0, 16'h0000);
    rd(16'h2468, "rail result");
    wr(`ISRP_PTR_POWER, 0, 16'h0000);
    rd(16'hC3E1, "power result");
    wr(`ISRP_PTR_MAKER, 0, 16'h0000);
    rd(`ISRP_MAKER_CODE, "maker code");
    // upper byte refused, then the same pointer read again in full
    ctl.start;
    ctl.send_byte(dev(1'b1), ack);
    ctl.recv_byte(1'b0, b);
    chk("early nack", {8'h00, b}, 16'h005A);
    rd(`ISRP_MAKER_CODE, "pointer kept");
    chk("hs kept", {15'h0000, hs_mode_r}, 16'h0001);
    // upper nibble is control, lower bits come from core status
    wr(`ISRP_PTR_FAULT, 2, 16'hFFFF);
    rd(16'hF123, "fault flags");
    chk("fault reads", frd_cnt[15:0], 16'h0002);
    // straps change between transactions and are taken each time
    for (i = 0; i < 16; i = i + 1) begin
      {sel_hi, sel_lo} = i[3:0];
      ctl.start;
      ctl.send_byte(dev(1'b0), ack);
      chk("own address", {15'h0000, ack}, 16'h0001);
    end
    ctl.start;
    ctl.send_byte(dev(1'b0) ^ 8'h40, ack);
    chk("foreign address", {15'h0000, ack}, 16'h0000);
    ctl.start;
    ctl.send_byte(8'h19, ack);
    chk("alert idle", {15'h0000, ack}, 16'h0000);
    alert_active = 1'b1;
    ctl.start;
    ctl.send_byte(8'h19, ack);
    ctl.recv_byte(1'b0, b);
    chk("alert id", {7'h00, ack, b}, {8'h01, dev(1'b1)});
    chk("alert won", won_cnt[15:0], 16'h0001);
    // a competitor with a lower address wins the identity byte
    ctl.start;
    ctl.send_byte(8'h19, ack);
    ctl.send_byte(8'h81, ack);
    chk("lost no ack", {15'h0000, ack}, 16'h0000);
    chk("alert lost", won_cnt[15:0], 16'h0001);
    ctl.stop;
    #200;
    chk("hs left", {15'h0000, hs_mode_r}, 16'h0000);
    test_done;
  end
endmodule
